// File: verilog/ptm_consts.svh
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH
`define PTM_OFF_CTRL0 12'h000
`define PTM_OFF_CTRL1 12'h004
`define PTM_OFF_CNTL 12'h008
`define PTM_OFF_CNTH 12'h00c
`define PTM_OFF_CMPAL 12'h010
`define PTM_OFF_CMPAH 12'h014
`define PTM_OFF_CMPPL 12'h018
`define PTM_OFF_CMPPH 12'h01c
`define PTM_OFF_IRQ_STAT 12'h020
`define PTM_OFF_IRQ_EN 12'h024
`define PTM_OFF_IRQ_CLR 12'h028
`define PTM_C0_PAUSE 7
`define PTM_C0_CKS_HI 6
`define PTM_C0_CKS_LO 4
`define PTM_C0_RUN 3
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_PIN_HI 5
`define PTM_C1_PIN_LO 4
`define PTM_C1_OC 3
`define PTM_C1_POL 2
`define PTM_C1_CAPS 1
`define PTM_C1_CCLR 0
`define PTM_C0_MASK 8'hf8
`define PTM_C0_RESET 8'h00
`define PTM_C1_RESET 8'h00
`define PTM_IRQ_A 0
`define PTM_IRQ_P 1
`define PTM_DIV16 8'd16
`define PTM_DIV64 8'd64
`define PTM_DIV4 8'd4
`endif

// File: verilog/ptm_pkg.sv
package ptm_pkg;
   typedef enum logic [1:0] {
      MODE_COMPARE,
      MODE_CAPTURE,
      MODE_PWM,
      MODE_TIMER
   } ptm_mode_t;
   typedef enum logic [2:0] {
      CK_SYS4,
      CK_SYS,
      CK_H16,
      CK_H64,
      CK_TBC,
      CK_H,
      CK_PIN_RISE,
      CK_PIN_FALL
   } ptm_clk_sel_t;
endpackage

// File: verilog/ptm_core.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ptm_consts.svh"
// Summary of operation
// RL1 - Ten-bit up counter clocked from a chosen internal or pin source.
// RL2 - Comparators A and P match the counter against two compare values.
// RL3 - Software cannot load the counter; its only way to zero it is a run rising edge.
// RL4 - Overflow or selected match clears the counter and raises an interrupt; while cclr is set, overflow raises no P event.
// RL5 - Pause bit freezes the counter; clearing it resumes from held value.
// RL6 - Three-bit clock select picks one of eight count sources.
// RL7 - Run bit set lets the counter count; clear stops it.
// RL8 - Run rising edge zeroes counter; falling edge keeps the residual value.
// RL9 - In compare output mode, run rising edge restores the initial pin level.
// RL10 - Counter is read-only; compare values split into low and high bytes.
// RL11 - One external input pin usable as clock; one output pin driven.
// RL12 - Mode field chooses compare, capture, PWM, or timer operation; capture mode latches no count here, the pin only holds its level.
// RL13 - Clear source: A match when set, else P match or overflow.
// RL14 - Pin function on A match: keep, low, high or toggle.
// RL15 - Output control bit gives initial level, or PWM active level.
// RL16 - Unimplemented control and high-byte bits ignore writes, read zero.
module ptm_core (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic HIGH_CLK_EN,
   input wire logic TIMEBASE_CLK_EN,
   input wire logic EXTERNAL_COUNT_PIN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic TIMER_OUT,
   output logic IRQ
);
   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl1_reg;
   logic [9:0] count_reg;
   logic [9:0] cmp_a_reg;
   logic [9:0] cmp_p_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_en_reg;
   logic run_d_reg;
   logic pin_lvl_reg;
   logic [2:0] pin_sync_reg;
   logic [7:0] div_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic out_reg;
   logic irq_reg;
   logic [5:0] hdiv_reg;

   // Bus decode; the access is answered in the second access cycle, after one wait state.
   wire access = PSEL && PENABLE && !PREADY;
   wire wr = access && PWRITE;
   wire [7:0] wbyte = PWDATA[7:0];
   wire hit = (PADDR <= `PTM_OFF_IRQ_CLR) && (PADDR[1:0] == 2'b00);

   wire run = ctrl0_reg[`PTM_C0_RUN];
   wire pause = ctrl0_reg[`PTM_C0_PAUSE];
   wire [2:0] cks = ctrl0_reg[`PTM_C0_CKS_HI:`PTM_C0_CKS_LO];
   wire [1:0] mode = ctrl1_reg[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
   wire [1:0] pinf = ctrl1_reg[`PTM_C1_PIN_HI:`PTM_C1_PIN_LO];
   wire oc = ctrl1_reg[`PTM_C1_OC];
   wire pol = ctrl1_reg[`PTM_C1_POL];
   wire cclr = ctrl1_reg[`PTM_C1_CCLR];

   // Only the agreeing second and third stages feed edge detection.
   wire pin_stable = (pin_sync_reg[2] == pin_sync_reg[1]);
   wire pin_rise = pin_stable && pin_sync_reg[1] && !pin_lvl_reg;
   wire pin_fall = pin_stable && !pin_sync_reg[1] && pin_lvl_reg;

   // Dividers are free-running so a source change never waits on them.
   wire sys4_en = (div_reg[1:0] == 2'b11);
   wire h16_en = HIGH_CLK_EN && (hdiv_reg[3:0] == 4'hf);
   wire h64_en = HIGH_CLK_EN && (hdiv_reg == 6'h3f);

   logic tick_src;
   always_comb begin
      case (ptm_pkg::ptm_clk_sel_t'(cks)) // [RL6]
         ptm_pkg::CK_SYS4: tick_src = sys4_en;
         ptm_pkg::CK_SYS: tick_src = 1'b1;
         ptm_pkg::CK_H16: tick_src = h16_en;
         ptm_pkg::CK_H64: tick_src = h64_en;
         ptm_pkg::CK_TBC: tick_src = TIMEBASE_CLK_EN;
         ptm_pkg::CK_H: tick_src = HIGH_CLK_EN;
         ptm_pkg::CK_PIN_RISE: tick_src = pin_rise; // [RL11]
         default: tick_src = pin_fall;
      endcase
   end

   wire tick = run && !pause && tick_src; // [RL5] [RL7]
   wire run_rise = run && !run_d_reg; // [RL8]

   // Matches fire on the tick that lands the counter on the compare value.
   wire [9:0] cnt_inc = count_reg + 10'h001;
   wire match_a = tick && (cnt_inc == cmp_a_reg); // [RL2]
   wire match_p = tick && (cnt_inc == cmp_p_reg) && (cmp_p_reg != 10'h000);
   wire ovf = tick && (count_reg == 10'h3ff);
   wire clr_a = cclr && match_a; // [RL13]
   wire clr_p = !cclr && (match_p || (ovf && cmp_p_reg == 10'h000));
   wire ev_a = match_a;
   wire ev_p = !cclr && (match_p || ovf); // [RL4]

   logic [9:0] count_next;
   always_comb begin
      if (run_rise) begin
         count_next = 10'h000; // [RL3] [RL8]
      end else if (clr_a || clr_p) begin
         count_next = 10'h000; // [RL4]
      end else if (tick) begin
         count_next = cnt_inc; // [RL1]
      end else begin
         count_next = count_reg;
      end
   end

   logic out_next;
   always_comb begin
      out_next = out_reg;
      if (ptm_pkg::ptm_mode_t'(mode) == ptm_pkg::MODE_COMPARE) begin // [RL12]
         if (run_rise) begin
            out_next = oc; // [RL9] [RL15]
         end else if (ev_a) begin
            case (pinf) // [RL14]
               2'b01: out_next = 1'b0;
               2'b10: out_next = 1'b1;
               2'b11: out_next = !out_reg;
               default: out_next = out_reg;
            endcase
         end
      end else if (ptm_pkg::ptm_mode_t'(mode) == ptm_pkg::MODE_PWM) begin
         // Active level is oc while below the duty point, else inactive.
         out_next = (count_next < cmp_a_reg) ? oc : !oc; // [RL15]
      end
   end

   wire [7:0] ctrl0_next = wbyte & `PTM_C0_MASK; // [RL16]
   wire [1:0] irq_stat_next = (irq_stat_reg &
      ~((wr && PADDR == `PTM_OFF_IRQ_CLR) ? PWDATA[1:0] : 2'b00)) |
      {ev_p, ev_a};

   logic [31:0] rd_mux;
   always_comb begin
      case (PADDR)
         `PTM_OFF_CTRL0: rd_mux = {24'h000000, ctrl0_reg};
         `PTM_OFF_CTRL1: rd_mux = {24'h000000, ctrl1_reg};
         `PTM_OFF_CNTL: rd_mux = {24'h000000, count_reg[7:0]}; // [RL10]
         `PTM_OFF_CNTH: rd_mux = {30'h00000000, count_reg[9:8]}; // [RL16]
         `PTM_OFF_CMPAL: rd_mux = {24'h000000, cmp_a_reg[7:0]};
         `PTM_OFF_CMPAH: rd_mux = {30'h00000000, cmp_a_reg[9:8]};
         `PTM_OFF_CMPPL: rd_mux = {24'h000000, cmp_p_reg[7:0]};
         `PTM_OFF_CMPPH: rd_mux = {30'h00000000, cmp_p_reg[9:8]};
         `PTM_OFF_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_reg};
         `PTM_OFF_IRQ_EN: rd_mux = {30'h00000000, irq_en_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         pin_sync_reg <= 3'h0;
         pin_lvl_reg <= 1'b0;
         div_reg <= 8'h00;
         hdiv_reg <= 6'h00;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], EXTERNAL_COUNT_PIN};
         if (pin_stable) begin
            pin_lvl_reg <= pin_sync_reg[1];
         end
         div_reg <= div_reg + 8'h01;
         if (HIGH_CLK_EN) begin
            hdiv_reg <= hdiv_reg + 6'h01;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         count_reg <= 10'h000;
         run_d_reg <= 1'b0;
         out_reg <= 1'b0;
         irq_stat_reg <= 2'b00;
         irq_reg <= 1'b0;
         TIMER_OUT <= 1'b0;
      end else begin
         count_reg <= count_next;
         run_d_reg <= run;
         out_reg <= out_next;
         irq_stat_reg <= irq_stat_next; // Set wins over clear.
         irq_reg <= |(irq_stat_next & irq_en_reg);
         TIMER_OUT <= (ptm_pkg::ptm_mode_t'(mode) == ptm_pkg::MODE_TIMER) ?
            1'b0 : (out_next ^ pol);
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl0_reg <= `PTM_C0_RESET;
         ctrl1_reg <= `PTM_C1_RESET;
         cmp_a_reg <= 10'h000;
         cmp_p_reg <= 10'h000;
         irq_en_reg <= 2'b00;
      end else if (wr) begin
         case (PADDR)
            `PTM_OFF_CTRL0: ctrl0_reg <= ctrl0_next;
            `PTM_OFF_CTRL1: ctrl1_reg <= wbyte;
            `PTM_OFF_CMPAL: cmp_a_reg[7:0] <= wbyte; // [RL10]
            `PTM_OFF_CMPAH: cmp_a_reg[9:8] <= wbyte[1:0]; // [RL16]
            `PTM_OFF_CMPPL: cmp_p_reg[7:0] <= wbyte;
            `PTM_OFF_CMPPH: cmp_p_reg[9:8] <= wbyte[1:0];
            `PTM_OFF_IRQ_EN: irq_en_reg <= wbyte[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access && !hit;
         if (access && !PWRITE) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign IRQ = irq_reg;

   a_run_rise_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
      run_rise |=> count_reg == 10'h000) // [RL8]
      else $error("Counter not zeroed on run rising edge.");
   a_pause_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (pause && !run_rise) |=> $stable(count_reg)) // [RL5]
      else $error("Counter moved while paused.");
   a_off_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (!run && run_d_reg == 1'b0) |=> $stable(count_reg)) // [RL7]
      else $error("Counter moved while off.");
   a_clear_on_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (cclr && match_a) |=> count_reg == 10'h000) // [RL13]
      else $error("Counter not cleared on A match.");
   a_irq_sticky: assert property (@(posedge CLOCK) disable iff (!RESETN)
      ev_a |=> irq_stat_reg[`PTM_IRQ_A]) // [RL4]
      else $error("A event did not set status.");
   a_init_level: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (run_rise && mode == 2'b00) |=> out_reg == $past(oc)) // [RL9]
      else $error("Output not restored to initial level.");
   a_toggle_out: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (mode == 2'b00 && ev_a && !run_rise && pinf == 2'b11)
      |=> out_reg != $past(out_reg)) // [RL14]
      else $error("Output did not toggle on A match.");
   a_count_step: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (tick && !run_rise && !clr_a && !clr_p)
      |=> count_reg == $past(count_reg) + 10'h001) // [RL1]
      else $error("Counter did not step on tick.");
   a_hi_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
      ctrl0_reg[2:0] == 3'h0) // [RL16]
      else $error("Unimplemented control bits set.");

   // Counter clear, hold and event checks.
   // Most name the cycle after the cause, since every state is a flop; a_no_p_when_a, a_irq_level and a_pause_no_event check the same cycle.
   a_clear_on_p: assert property ( // [RL13]
      @(posedge CLOCK) disable iff (!RESETN)
      (!cclr && match_p) |=> count_reg == 10'h000)
      else $error("Counter not cleared on P match.");
   a_ovf_wrap: assert property ( // [RL4]
      @(posedge CLOCK) disable iff (!RESETN)
      ovf |=> count_reg == 10'h000)
      else $error("Counter not zero after overflow.");
   a_irq_p_sticky: assert property ( // [RL4]
      @(posedge CLOCK) disable iff (!RESETN)
      ev_p |=> irq_stat_reg[`PTM_IRQ_P])
      else $error("P event did not set status.");
   a_no_p_when_a: assert property ( // [RL13]
      @(posedge CLOCK) disable iff (!RESETN)
      cclr |-> !ev_p)
      else $error("P event raised while A clears the counter.");
   a_clear_status: assert property ( // [RL4]
      @(posedge CLOCK) disable iff (!RESETN)
      (wr && PADDR == `PTM_OFF_IRQ_CLR && PWDATA[0] && !ev_a)
      |=> !irq_stat_reg[`PTM_IRQ_A])
      else $error("A status not cleared by write.");
   a_irq_level: assert property ( // [RL4]
      @(posedge CLOCK) disable iff (!RESETN)
      $stable(irq_en_reg) |-> IRQ == |(irq_stat_reg & irq_en_reg))
      else $error("Interrupt level disagrees with status.");
   a_pause_no_event: assert property ( // [RL5]
      @(posedge CLOCK) disable iff (!RESETN)
      pause |-> !ev_a)
      else $error("Match event while paused.");
   a_run_fall_keep: assert property ( // [RL8]
      @(posedge CLOCK) disable iff (!RESETN)
      (!run && run_d_reg) |=> $stable(count_reg))
      else $error("Residual count lost on run falling edge.");
   a_ro_count: assert property ( // [RL3]
      @(posedge CLOCK) disable iff (!RESETN)
      (wr && PADDR == `PTM_OFF_CNTL && !tick && !run_rise)
      |=> $stable(count_reg))
      else $error("Counter changed by a register write.");

   // Clock source checks.
   a_sys4_rate: assert property ( // [RL6]
      @(posedge CLOCK) disable iff (!RESETN)
      sys4_en |=> !sys4_en)
      else $error("Quarter-rate enable lasted two cycles.");
   a_tbc_tick: assert property ( // [RL6]
      @(posedge CLOCK) disable iff (!RESETN)
      (run && !pause && cks == 3'b100 && TIMEBASE_CLK_EN) |-> tick)
      else $error("Timebase enable gave no count tick.");
   a_ext_rise_once: assert property ( // [RL11]
      @(posedge CLOCK) disable iff (!RESETN)
      pin_rise |=> !pin_rise)
      else $error("One pin edge counted twice.");

   // Output pin checks.
   a_pin_low: assert property ( // [RL14]
      @(posedge CLOCK) disable iff (!RESETN)
      (mode == 2'b00 && ev_a && !run_rise && pinf == 2'b01) |=> !out_reg)
      else $error("Output not driven low on A match.");
   a_pin_high: assert property ( // [RL14]
      @(posedge CLOCK) disable iff (!RESETN)
      (mode == 2'b00 && ev_a && !run_rise && pinf == 2'b10) |=> out_reg)
      else $error("Output not driven high on A match.");
   a_timer_pin_low: assert property ( // [RL12]
      @(posedge CLOCK) disable iff (!RESETN)
      (mode == 2'b11) |=> !TIMER_OUT)
      else $error("Output pin driven in timer mode.");
   a_pwm_level: assert property ( // [RL15]
      @(posedge CLOCK) disable iff (!RESETN)
      (mode == 2'b10) |=> TIMER_OUT == (((count_reg < $past(cmp_a_reg)) ?
      $past(oc) : !$past(oc)) ^ $past(pol)))
      else $error("PWM output level wrong.");

   // Register interface checks.
   a_cmp_a_written: assert property ( // [RL10]
      @(posedge CLOCK) disable iff (!RESETN)
      (wr && PADDR == `PTM_OFF_CMPAL) |=> cmp_a_reg[7:0] == $past(wbyte))
      else $error("Compare A low byte not written.");
   a_cmp_p_written: assert property ( // [RL10]
      @(posedge CLOCK) disable iff (!RESETN)
      (wr && PADDR == `PTM_OFF_CMPPL) |=> cmp_p_reg[7:0] == $past(wbyte))
      else $error("Compare P low byte not written.");
   a_ctrl0_mask: assert property ( // [RL16]
      @(posedge CLOCK) disable iff (!RESETN)
      (wr && PADDR == `PTM_OFF_CTRL0) |=> ctrl0_reg == ($past(wbyte) & 8'hf8))
      else $error("Control zero write not masked.");
   a_high_bytes: assert property ( // [RL16]
      @(posedge CLOCK) disable iff (!RESETN)
      (access && !PWRITE && PADDR == `PTM_OFF_CMPAH) |=> PRDATA[31:2] == 30'h0)
      else $error("Unimplemented high-byte bits read nonzero.");
   a_ready_answer: assert property ( // [RL10]
      @(posedge CLOCK) disable iff (!RESETN)
      access |=> PREADY)
      else $error("Access not answered in one cycle.");
   a_ready_pulse: assert property ( // [RL10]
      @(posedge CLOCK) disable iff (!RESETN)
      PREADY |=> !PREADY)
      else $error("Ready held longer than one cycle.");
   a_slverr: assert property ( // [RL16]
      @(posedge CLOCK) disable iff (!RESETN)
      (access && !hit) |=> PSLVERR)
      else $error("Unmapped access gave no error.");

   c_match_a: cover property (@(posedge CLOCK) disable iff (!RESETN) ev_a);
   c_overflow: cover property (@(posedge CLOCK) disable iff (!RESETN) ovf);
   c_irq: cover property (@(posedge CLOCK) disable iff (!RESETN) IRQ);
   c_pin_clock: cover property (@(posedge CLOCK) disable iff (!RESETN)
      tick && cks[2:1] == 2'b11);
   c_pwm: cover property (@(posedge CLOCK) disable iff (!RESETN)
      mode == 2'b10 && tick);
endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps
`include "ptm_consts.svh"
module tb_top;
   logic CLOCK, RESETN, HIGH_CLK_EN, TIMEBASE_CLK_EN, EXTERNAL_COUNT_PIN;
   logic PSEL, PENABLE, PWRITE;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic PREADY, PSLVERR, TIMER_OUT, IRQ;
   logic [32:0] exp_q[$];
   int miscompares = 0;
   int num_checks = 0;
   int seed = 33;
   int n;
   logic oc, pin_exp;

   ptm_core uut (.CLOCK(CLOCK), .RESETN(RESETN), .HIGH_CLK_EN(HIGH_CLK_EN),
      .TIMEBASE_CLK_EN(TIMEBASE_CLK_EN),
      .EXTERNAL_COUNT_PIN(EXTERNAL_COUNT_PIN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));

   task automatic test_done();
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      num_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            want);
      end
   endtask

   task automatic pin(input logic seen, input logic want);
      check({32'h0, seen}, {32'h0, want});
   endtask

   // The request is held until PREADY is sampled high, then released.
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      if (PREADY !== 1'b1) begin
         miscompares++;
         test_done();
      end else begin
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         @(posedge CLOCK);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Pin pulses are two cycles wide so the input synchroniser sees them.
   task automatic pulse(input int k, input int s);
      for (int i = 0; i < k; i++) begin
         if (s == 4) TIMEBASE_CLK_EN <= 1'b1;
         if (s == 5) HIGH_CLK_EN <= 1'b1;
         if (s >= 6) EXTERNAL_COUNT_PIN <= 1'b1;
         @(posedge CLOCK);
         TIMEBASE_CLK_EN <= 1'b0;
         HIGH_CLK_EN <= 1'b0;
         @(posedge CLOCK);
         EXTERNAL_COUNT_PIN <= 1'b0;
         repeat (2) @(posedge CLOCK);
      end
      repeat (6) @(posedge CLOCK);
   endtask

   always @(posedge CLOCK) begin
      if (PREADY === 1'b1 && PSEL === 1'b1 && PWRITE === 1'b0) begin
         if (exp_q.size() > 0) check({PSLVERR, PRDATA}, exp_q.pop_front());
         else miscompares++;
      end
   end

   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end

   initial begin
      RESETN = 1'b0;
      HIGH_CLK_EN = 1'b0;
      TIMEBASE_CLK_EN = 1'b0;
      EXTERNAL_COUNT_PIN = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      repeat (3) @(posedge CLOCK);
      RESETN <= 1'b1;
      @(posedge CLOCK);
      pin(IRQ, 1'b0);
      rd(`PTM_OFF_CTRL0, 33'h0);
      rd(`PTM_OFF_CTRL1, 33'h0);
      rd(`PTM_OFF_IRQ_STAT, 33'h0);
      rd(12'h030, 33'h100000000);
      wr(`PTM_OFF_CTRL0, 32'hff);
      rd(`PTM_OFF_CTRL0, 33'hf8);
      wr(`PTM_OFF_CTRL0, 32'h0);
      wr(`PTM_OFF_CMPAH, 32'hff);
      rd(`PTM_OFF_CMPAH, 33'h3);
      wr(`PTM_OFF_CMPAL, 32'h1a5);
      rd(`PTM_OFF_CMPAL, 33'ha5);
      for (int s = 4; s < 8; s++) begin
         n = $random(seed);
         n = 1 + (n & 15);
         wr(`PTM_OFF_CTRL0, 32'h88 | 32'(s << 4));
         wr(`PTM_OFF_CNTL, 32'hff);
         rd(`PTM_OFF_CNTL, 33'h0);
         wr(`PTM_OFF_CTRL0, 32'h08 | 32'(s << 4));
         pulse(n, s);
         rd(`PTM_OFF_CNTL, 33'(n));
         wr(`PTM_OFF_CTRL0, 32'h88 | 32'(s << 4));
         pulse(3, s);
         rd(`PTM_OFF_CNTL, 33'(n));
         wr(`PTM_OFF_CTRL0, 32'h08 | 32'(s << 4));
         pulse(1, s);
         wr(`PTM_OFF_CTRL0, 32'(s << 4));
         pulse(2, s);
         rd(`PTM_OFF_CNTL, 33'(n + 1));
      end
      wr(`PTM_OFF_IRQ_CLR, 32'h3);
      wr(`PTM_OFF_CMPAL, 32'h5);
      wr(`PTM_OFF_CMPAH, 32'h0);
      wr(`PTM_OFF_IRQ_EN, 32'h3);
      for (int f = 0; f < 4; f++) begin
         n = $random(seed);
         oc = n[0];
         pin_exp = (f == 0) ? oc : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : ~oc;
         wr(`PTM_OFF_CTRL0, 32'h0);
         wr(`PTM_OFF_CTRL1, {26'h0, f[1:0], oc, 3'b001});
         wr(`PTM_OFF_CTRL0, 32'h48);
         pin(TIMER_OUT, oc);
         pulse(5, 4);
         pin(TIMER_OUT, pin_exp);
         pin(IRQ, 1'b1);
         rd(`PTM_OFF_IRQ_STAT, 33'h1);
         rd(`PTM_OFF_CNTL, 33'h0);
         wr(`PTM_OFF_IRQ_CLR, 32'h3);
         pin(IRQ, 1'b0);
      end
      wr(`PTM_OFF_CTRL0, 32'h0);
      wr(`PTM_OFF_CTRL1, 32'hc0);
      wr(`PTM_OFF_CMPPL, 32'h3);
      wr(`PTM_OFF_IRQ_EN, 32'h1);
      wr(`PTM_OFF_CTRL0, 32'h48);
      pulse(3, 4);
      rd(`PTM_OFF_IRQ_STAT, 33'h2);
      rd(`PTM_OFF_CNTL, 33'h0);
      pin(IRQ, 1'b0);
      pin(TIMER_OUT, 1'b0);
      wr(`PTM_OFF_IRQ_EN, 32'h3);
      pin(IRQ, 1'b1);
      wr(`PTM_OFF_IRQ_CLR, 32'h2);
      wr(`PTM_OFF_CTRL0, 32'h0);
      wr(`PTM_OFF_CMPPL, 32'h0);
      wr(`PTM_OFF_CTRL0, 32'h48);
      pulse(1024, 4);
      rd(`PTM_OFF_IRQ_STAT, 33'h3);
      rd(`PTM_OFF_CNTL, 33'h0);
      // PWM with an inverted pin: low while below compare A of 5, high from 5 on.
      wr(`PTM_OFF_CTRL0, 32'h0);
      wr(`PTM_OFF_CTRL1, 32'h8c);
      wr(`PTM_OFF_CTRL0, 32'h48);
      pin(TIMER_OUT, 1'b0);
      pulse(6, 4);
      pin(TIMER_OUT, 1'b1);
      repeat (4) @(posedge CLOCK);
      if (exp_q.size() != 0) miscompares++;
      test_done();
   end
endmodule
